// ### dtab_pkg.sv
// dtab_pkg: constants, register map and carrier types of the
// block cipher datapath.
// assumes: shared by the datapath and by whatever binds its core port.
package dtab_pkg;

    // ------------------------------------------------------------
    // register map (byte addresses of 32-bit words; key spans eight words, iv four)
    // ------------------------------------------------------------
    localparam logic [7:0] OFF_CTL  = 8'h00;
    localparam logic [7:0] OFF_STAT = 8'h04;
    localparam logic [7:0] OFF_DIN  = 8'h08;
    localparam logic [7:0] OFF_DOUT = 8'h0c;
    localparam logic [7:0] OFF_KEY  = 8'h10;
    localparam logic [7:0] OFF_IV   = 8'h30;
    localparam logic [7:0] OFF_END  = 8'h40;

    // control word layout, bit 11 downward
    typedef struct packed {
        logic [1:0] auth_phase_sel;
        logic [1:0] data_swap_type;
        logic [1:0] key_size;
        logic [3:0] algorithm_mode_sel;
        logic       dir_dec;
        logic       enable;
    } dtab_ctl_s;
    localparam int unsigned CTL_FLUSH_BIT = 12;
    localparam logic [11:0] CTL_RST       = 12'h000;

    // algorithm codes
    localparam logic [3:0] ALG_TDES_ECB = 4'h0;
    localparam logic [3:0] ALG_TDES_CBC = 4'h1;
    localparam logic [3:0] ALG_DES_ECB  = 4'h2;
    localparam logic [3:0] ALG_DES_CBC  = 4'h3;
    localparam logic [3:0] ALG_AES_ECB  = 4'h4;
    localparam logic [3:0] ALG_AES_CBC  = 4'h5;
    localparam logic [3:0] ALG_AES_CTR  = 4'h6;
    localparam logic [3:0] ALG_AES_GCM  = 4'h8;

    // data swap types, key sizes, authentication phases
    localparam logic [1:0] SWP_NONE = 2'h0;
    localparam logic [1:0] SWP_HALF = 2'h1;
    localparam logic [1:0] SWP_BYTE = 2'h2;
    localparam logic [1:0] SWP_BIT  = 2'h3;
    localparam logic [1:0] KSZ_128  = 2'h0;
    localparam logic [1:0] KSZ_192  = 2'h1;
    localparam logic [1:0] PH_PREP  = 2'h0;
    localparam logic [1:0] PH_AAD   = 2'h1;
    localparam logic [1:0] PH_PAY   = 2'h2;
    localparam logic [1:0] PH_TAG   = 2'h3;

    // counter and field multiplier constants
    localparam logic [31:0] CTR_ONE   = 32'h0000_0001;
    localparam logic [7:0]  GF_R_TOP  = 8'he1;
    localparam logic [7:0]  GF_LAST   = 8'h7f;

    // request to the attached cipher core
    typedef enum logic [1:0] {CK_ENC, CK_DEC, CK_KEYX} dtab_kind_e;
    typedef struct packed {
        dtab_kind_e   kind;
        logic         is_aes;
        logic [1:0]   key_size;
        logic [255:0] key;
        logic [127:0] data;
    } dtab_core_req_s;

endpackage

// ### dtab_cipher.sv
// dtab_cipher: register port, data FIFOs, swapping, chaining, counter
// and GCM hash around an attached DES/AES core.
// assumes: the core takes a one-cycle request when idle and answers
// once with core_done_i; one synchronous clock domain.
//
// Chosen here: the register offsets and the strobed register port.
`timescale 1ns/1ps

module dtab_cipher #(
    parameter int unsigned FIFO_DEPTH = 8,
    parameter int unsigned PTR_W      = 3
) (
    input  wire logic                    clk_i,
    input  wire logic                    rst_i,
    input  wire logic [7:0]              addr_i,
    input  wire logic [31:0]             wdata_i,
    input  wire logic                    we_i,
    input  wire logic                    re_i,
    output logic      [31:0]             rdata_o,
    output logic                         core_req_valid_o,
    output dtab_pkg::dtab_core_req_s     core_req_o,
    input  wire logic                    core_done_i,
    input  wire logic [127:0]            core_data_i
);
    import dtab_pkg::*;

    typedef enum logic [3:0] {
        S_IDLE, S_KEYX, S_KWAIT, S_WAIT, S_POP, S_PREP,
        S_REQ, S_CORE, S_FIN, S_MUL, S_PUSH
    } dtab_state_e;

    // ------------------------------------------------------------
    // helper functions
    // ------------------------------------------------------------
    // reorder one word per data type
    function automatic logic [31:0] swap_w(input logic [31:0] w,
                                           input logic [1:0]  t);
        logic [31:0] r;
        r = w;
        unique case (t)
            SWP_NONE: r = w;
            SWP_HALF: r = {w[15:0], w[31:16]};
            SWP_BYTE: r = {w[7:0], w[15:8], w[23:16], w[31:24]};
            SWP_BIT:  for (int i = 0; i < 32; i++) r[i] = w[31-i];
        endcase
        return r;
    endfunction

    function automatic logic [127:0] swap_b(input logic [127:0] b,
                                            input logic [1:0]   t);
        return {swap_w(b[127:96], t), swap_w(b[95:64], t),
                swap_w(b[63:32], t), swap_w(b[31:0], t)};
    endfunction

    // add one to the low counter field only
    function automatic logic [127:0] inc32(input logic [127:0] c);
        return {c[127:32], c[31:0] + CTR_ONE};
    endfunction

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    dtab_ctl_s          ctl_q;
    logic [31:0]        key_q [8];
    logic [31:0]        iv_q  [4];
    logic [31:0]        ifm_q [FIFO_DEPTH];
    logic [31:0]        ofm_q [FIFO_DEPTH];
    logic [PTR_W-1:0]   iwp_q, irp_q, owp_q, orp_q;
    logic [PTR_W:0]     icnt_q, ocnt_q;
    dtab_state_e        st_q, ret_q;
    logic [7:0]         cnt_q;
    logic [1:0]         pass_q;
    logic [127:0]       blk_q, x_q, chain_q, cin_q, res_q, ob_q;
    logic [127:0]       gh_q, hk_q, gz_q, gv_q, gx_q;
    logic [31:0]        rdata_q;

    // ------------------------------------------------------------
    // register decode
    // ------------------------------------------------------------
    wire       sel_ctl  = addr_i == OFF_CTL;
    wire       sel_stat = addr_i == OFF_STAT;
    wire       sel_din  = addr_i == OFF_DIN;
    wire       sel_dout = addr_i == OFF_DOUT;
    wire       key_hit  = addr_i >= OFF_KEY && addr_i < OFF_IV;
    wire       iv_hit   = addr_i >= OFF_IV && addr_i < OFF_END;
    wire [7:0] key_off  = addr_i - OFF_KEY;
    wire [7:0] iv_off   = addr_i - OFF_IV;
    wire [2:0] key_idx  = key_off[4:2];
    wire [1:0] iv_idx   = iv_off[3:2];

    // mode decode
    wire [3:0] alg    = ctl_q.algorithm_mode_sel;
    wire       gcm    = alg == ALG_AES_GCM;
    wire       ctr    = alg == ALG_AES_CTR;
    wire       is_aes = alg == ALG_AES_ECB || alg == ALG_AES_CBC || ctr
                        || gcm;
    wire       tdes   = alg == ALG_TDES_ECB || alg == ALG_TDES_CBC;
    wire       cbc    = alg == ALG_TDES_CBC || alg == ALG_DES_CBC
                        || alg == ALG_AES_CBC;
    wire       dec    = ctl_q.dir_dec;
    wire [1:0] ph     = ctl_q.auth_phase_sel;
    wire [7:0] nw_m1  = is_aes ? 8'h03 : 8'h01;
    wire [1:0] np_m1  = tdes ? 2'h2 : 2'h0;
    wire       keyx   = is_aes && dec && !ctr && !gcm;

    // fifo flags
    wire in_full   = icnt_q == (PTR_W+1)'(FIFO_DEPTH);
    wire out_full  = ocnt_q == (PTR_W+1)'(FIFO_DEPTH);
    wire in_empty  = icnt_q == '0;
    wire out_empty = ocnt_q == '0;
    wire busy      = !(st_q == S_IDLE || st_q == S_WAIT);
    wire push_in   = we_i && sel_din && !in_full;
    wire pop_in    = st_q == S_POP;
    wire push_out  = st_q == S_PUSH && !out_full;
    wire pop_out   = re_i && sel_dout && !out_empty;
    wire flush     = we_i && sel_ctl && wdata_i[CTL_FLUSH_BIT]
                     && !wdata_i[0];
    wire have_blk  = {4'h0, icnt_q} > nw_m1;

    // ------------------------------------------------------------
    // core request: key slot and direction per pass
    // ------------------------------------------------------------
    // des key slot: encrypt 1,2,3; decrypt 3,2,1; single DES slot 1
    wire [1:0] dslot = !dec ? pass_q + 2'h1
                     : (tdes ? 2'h3 - pass_q : 2'h1);
    wire [63:0] s0 = {key_q[0], key_q[1]};
    wire [63:0] s1 = {key_q[2], key_q[3]};
    wire [63:0] s2 = {key_q[4], key_q[5]};
    wire [63:0] s3 = {key_q[6], key_q[7]};
    wire [63:0] dkey = dslot == 2'h1 ? s1 : (dslot == 2'h2 ? s2 : s3);
    // aes key left aligned, upper slots first
    wire [255:0] akey = ctl_q.key_size == KSZ_128 ? {s3, s2, 128'h0}
                      : ctl_q.key_size == KSZ_192 ? {s3, s2, s1, 64'h0}
                      : {s3, s2, s1, s0};
    // even passes follow the direction, odd passes invert it
    wire des_enc = pass_q[0] == dec;
    wire aes_dec = dec && !ctr && !gcm;

    assign core_req_valid_o   = st_q == S_REQ || st_q == S_KEYX;
    assign core_req_o.kind    = (st_q == S_KEYX || st_q == S_KWAIT) ? CK_KEYX
                              : (is_aes ? (aes_dec ? CK_DEC : CK_ENC)
                                        : (des_enc ? CK_ENC : CK_DEC));
    assign core_req_o.is_aes   = is_aes;
    assign core_req_o.key_size = ctl_q.key_size;
    assign core_req_o.key      = is_aes ? akey : {dkey, 192'h0};
    assign core_req_o.data     = cin_q;

    // ------------------------------------------------------------
    // block datapath values
    // ------------------------------------------------------------
    wire [127:0] xs    = swap_b(blk_q, ctl_q.data_swap_type);
    wire [127:0] fin_r = (gcm && ph == PH_TAG) ? res_q ^ gh_q
                       : (ctr || gcm) ? res_q ^ x_q
                       : (cbc && dec) ? res_q ^ chain_q
                       : res_q;
    wire [127:0] fin_s = swap_b(fin_r, ctl_q.data_swap_type);
    wire [127:0] gv_sh = {1'b0, gv_q[127:1]}
                       ^ (gv_q[0] ? {GF_R_TOP, 120'h0} : 128'h0);
    wire [127:0] gz_n  = gz_q ^ (gx_q[127] ? gv_q : 128'h0);
    wire [127:0] iv_w  = is_aes ? {iv_q[0], iv_q[1], iv_q[2], iv_q[3]}
                                : {64'h0, iv_q[0], iv_q[1]};

    // read data mux; keys read as zero
    wire [31:0] rd_d = sel_ctl  ? {20'h0, ctl_q}
                     : sel_stat ? {27'h0, out_full, !out_empty, in_empty,
                                   !in_full, busy}
                     : sel_dout ? ofm_q[orp_q]
                     : iv_hit   ? iv_q[iv_idx]
                     : 32'h0000_0000;

    // ------------------------------------------------------------
    // register port and fifos
    // ------------------------------------------------------------
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            rdata_q <= '0;
            iwp_q   <= '0;
            irp_q   <= '0;
            icnt_q  <= '0;
            owp_q   <= '0;
            orp_q   <= '0;
            ocnt_q  <= '0;
            for (int i = 0; i < 8; i++) key_q[i] <= '0;
            for (int i = 0; i < 4; i++) iv_q[i] <= '0;
        end else begin
            rdata_q <= re_i ? rd_d : '0;
            if (we_i && key_hit) key_q[key_idx] <= wdata_i;
            if (we_i && iv_hit && !busy) begin
                iv_q[iv_idx] <= wdata_i;
            end
            if (push_in) ifm_q[iwp_q] <= wdata_i;
            if (push_out) ofm_q[owp_q] <= ob_q[127:96];
            if (flush) begin
                iwp_q  <= '0;
                irp_q  <= '0;
                icnt_q <= '0;
                owp_q  <= '0;
                orp_q  <= '0;
                ocnt_q <= '0;
            end else begin
                iwp_q  <= iwp_q + PTR_W'(push_in);
                irp_q  <= irp_q + PTR_W'(pop_in);
                icnt_q <= icnt_q + (PTR_W+1)'(push_in)
                          - (PTR_W+1)'(pop_in);
                owp_q  <= owp_q + PTR_W'(push_out);
                orp_q  <= orp_q + PTR_W'(pop_out);
                ocnt_q <= ocnt_q + (PTR_W+1)'(push_out)
                          - (PTR_W+1)'(pop_out);
            end
        end
    end

    assign rdata_o = rdata_q;

    // ------------------------------------------------------------
    // sequencer: one block at a time through all its passes
    // ------------------------------------------------------------
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            st_q    <= S_IDLE;
            ret_q   <= S_IDLE;
            ctl_q   <= dtab_ctl_s'(CTL_RST);
            cnt_q   <= '0;
            pass_q  <= '0;
            blk_q   <= '0;
            x_q     <= '0;
            chain_q <= '0;
            cin_q   <= '0;
            res_q   <= '0;
            ob_q    <= '0;
            gh_q    <= '0;
            hk_q    <= '0;
            gz_q    <= '0;
            gv_q    <= '0;
            gx_q    <= '0;
        end else begin
            unique case (st_q)
                S_IDLE: if (ctl_q.enable) begin
                    chain_q <= iv_w;
                    pass_q  <= '0;
                    if (gcm && ph == PH_PREP) begin
                        cin_q <= '0;
                        st_q  <= S_REQ;
                    end else begin
                        st_q <= keyx ? S_KEYX : S_WAIT;
                    end
                end
                S_KEYX: st_q <= S_KWAIT;
                S_KWAIT: if (core_done_i) st_q <= S_WAIT;
                S_WAIT: begin
                    cnt_q <= '0;
                    if (!ctl_q.enable) st_q <= S_IDLE;
                    else if (have_blk) st_q <= S_POP;
                end
                S_POP: begin
                    blk_q <= {blk_q[95:0], ifm_q[irp_q]};
                    cnt_q <= cnt_q + 8'h01;
                    if (cnt_q == nw_m1) st_q <= S_PREP;
                end
                S_PREP: begin
                    x_q    <= xs;
                    pass_q <= '0;
                    gz_q   <= '0;
                    gv_q   <= hk_q;
                    cnt_q  <= '0;
                    if (gcm && (ph == PH_AAD || ph == PH_TAG)) begin
                        gx_q  <= gh_q ^ xs;
                        cin_q <= {chain_q[127:32], CTR_ONE};
                        ret_q <= ph == PH_AAD ? S_WAIT : S_REQ;
                        st_q  <= S_MUL;
                    end else begin
                        if (gcm) begin
                            cin_q   <= inc32(chain_q);
                            chain_q <= inc32(chain_q);
                        end else if (ctr) begin
                            cin_q   <= chain_q;
                            chain_q <= inc32(chain_q);
                        end else if (cbc && !dec) begin
                            cin_q <= xs ^ chain_q;
                        end else begin
                            cin_q <= xs;
                        end
                        st_q <= S_REQ;
                    end
                end
                S_REQ: st_q <= S_CORE;
                S_CORE: if (core_done_i) begin
                    if (pass_q != np_m1) begin
                        cin_q  <= core_data_i;
                        pass_q <= pass_q + 2'h1;
                        st_q   <= S_REQ;
                    end else begin
                        res_q <= core_data_i;
                        st_q  <= S_FIN;
                    end
                end
                S_FIN: begin
                    cnt_q <= '0;
                    if (cbc) begin
                        chain_q <= dec ? x_q : res_q;
                    end
                    ob_q <= is_aes ? fin_s : {fin_s[63:0], 64'h0};
                    gz_q <= '0;
                    gv_q <= hk_q;
                    if (gcm && ph == PH_PREP) begin
                        hk_q          <= res_q;
                        gh_q          <= '0;
                        ctl_q.enable  <= 1'b0;
                        st_q          <= S_IDLE;
                    end else if (gcm && ph == PH_PAY) begin
                        gx_q  <= gh_q ^ (dec ? x_q : fin_r);
                        ret_q <= S_PUSH;
                        st_q  <= S_MUL;
                    end else begin
                        st_q <= S_PUSH;
                    end
                end
                S_MUL: begin
                    gz_q  <= gz_n;
                    gv_q  <= gv_sh;
                    gx_q  <= {gx_q[126:0], 1'b0};
                    cnt_q <= cnt_q + 8'h01;
                    if (cnt_q == GF_LAST) begin
                        gh_q  <= gz_n;
                        cnt_q <= '0;
                        st_q  <= ret_q;
                    end
                end
                S_PUSH: if (!out_full) begin
                    ob_q  <= {ob_q[95:0], 32'h0};
                    cnt_q <= cnt_q + 8'h01;
                    if (cnt_q == nw_m1) st_q <= S_WAIT;
                end
            endcase
            // a software write lands after the hardware clear
            if (we_i && sel_ctl) ctl_q <= dtab_ctl_s'(wdata_i[11:0]);
        end
    end

endmodule

// ### dtab_core_model.sv
// dtab_core_model: behavioural cipher core answering the datapath requests.
// assumes: one request at a time; answers after one or four idle cycles.
`timescale 1ns/1ps
package dtab_mdl_pkg;
    // toy reversible rounds: rotate then mix key, and the inverse
    function automatic logic [63:0] de(logic [63:0] d, logic [63:0] k);
        return {d[62:0], d[63]} ^ k;
    endfunction
    function automatic logic [63:0] dd(logic [63:0] d, logic [63:0] k);
        logic [63:0] x;
        x = d ^ k;
        return {x[0], x[63:1]};
    endfunction
    function automatic logic [127:0] ae(logic [127:0] d, logic [127:0] k);
        return {d[126:0], d[127]} ^ k;
    endfunction
    function automatic logic [127:0] ad(logic [127:0] d, logic [127:0] k);
        logic [127:0] x;
        x = d ^ k;
        return {x[0], x[127:1]};
    endfunction
endpackage

module dtab_core_model (
    input  wire logic                clk_i,
    input  wire logic                rst_i,
    input  wire logic                req_valid_i,
    input  dtab_pkg::dtab_core_req_s req_i,
    output logic                     done_o,
    output logic [127:0]             data_o
);
    import dtab_pkg::*;
    import dtab_mdl_pkg::*;
    dtab_core_req_s r_q;
    logic [2:0]     cnt_q;
    logic           slow_q, kx_q, busy_q;
    logic [127:0]   res_q, ka, rd, ra;
    // aes key folds every slot so stray key bits show up
    assign ka = r_q.key[255:128] ^ r_q.key[127:0];
    assign rd = (r_q.kind == CK_DEC) ? {64'h0, dd(r_q.data[63:0],
                r_q.key[255:192])} : {64'h0, de(r_q.data[63:0],
                r_q.key[255:192])};
    // decrypt without a prior key schedule gives garbage
    assign ra = (r_q.kind == CK_ENC) ? ae(r_q.data, ka) :
                kx_q ? ad(r_q.data, ka) : ~ad(r_q.data, ka);
    // released result lines show the inverse of the last answer
    assign data_o = done_o ? res_q : ~res_q;
    // latency alternates between short and long answers
    always_ff @(posedge clk_i) begin
        done_o <= 1'b0;
        if (rst_i) begin
            busy_q <= 1'b0;
            kx_q   <= 1'b0;
            slow_q <= 1'b0;
            cnt_q  <= 3'h0;
            res_q  <= 128'h0;
        end else if (req_valid_i) begin
            r_q    <= req_i;
            busy_q <= 1'b1;
            slow_q <= ~slow_q;
            cnt_q  <= slow_q ? 3'h4 : 3'h1;
        end else if (busy_q) begin
            cnt_q <= cnt_q - 3'h1;
            if (cnt_q == 3'h1) begin
                busy_q <= 1'b0;
                done_o <= 1'b1;
                res_q  <= r_q.is_aes ? ra : rd;
                if (r_q.kind == CK_KEYX) begin
                    kx_q <= 1'b1;
                end
            end
        end
    end
endmodule

// ### dtab_cipher_assertions.sv
// dtab_cipher_assertions: port-level checks of the cipher datapath.
// assumes: bound to dtab_cipher; one clock, synchronous reset.
`timescale 1ns/1ps
module dtab_cipher_checker (
    input wire logic                clk_i,
    input wire logic                rst_i,
    input wire logic [7:0]          addr_i,
    input wire logic [31:0]         wdata_i,
    input wire logic                we_i,
    input wire logic                re_i,
    input wire logic [31:0]         rdata_o,
    input wire logic                core_req_valid_o,
    input dtab_pkg::dtab_core_req_s core_req_o,
    input wire logic                core_done_i,
    input wire logic [127:0]        core_data_i
);
    import dtab_pkg::*;
    logic pend_q;
    // tracks a core request still waiting for its answer
    always_ff @(posedge clk_i) begin
        if (rst_i || core_done_i) pend_q <= 1'b0;
        else if (core_req_valid_o) pend_q <= 1'b1;
    end
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    a_rd_idle_zero: assert property (!$past(re_i) |-> rdata_o == 32'h0)
        else $error("read data not zero outside read cycle");
    a_unmapped_rd: assert property (re_i && addr_i >= OFF_END |=>
        rdata_o == 32'h0) else $error("unmapped read not zero");
    a_key_rd_zero: assert property (re_i && addr_i >= OFF_KEY &&
        addr_i < OFF_IV |=> rdata_o == 32'h0) else $error("key readable");
    a_ctl_top_zero: assert property (re_i && addr_i == OFF_CTL |=>
        rdata_o[31:12] == 20'h0) else $error("flush or upper ctl bits read");
    a_req_one_pulse: assert property (core_req_valid_o |=> !core_req_valid_o)
        else $error("core request longer than one cycle");
    a_req_held: assert property (pend_q && !core_done_i |->
        $stable(core_req_o)) else $error("core request changed while pending");
    a_one_pending: assert property (pend_q |-> !core_req_valid_o)
        else $error("second core request while one pending");
    a_done_gap: assert property (core_done_i |-> !core_req_valid_o)
        else $error("core request in the answer cycle");
    a_aes_key_128: assert property (
        core_req_valid_o && core_req_o.is_aes &&
        core_req_o.key_size == KSZ_128 |-> core_req_o.key[127:0] == 128'h0)
        else $error("aes 128 key uses lower slots");
    c_keyx: cover property (core_req_valid_o && core_req_o.kind == CK_KEYX);
    c_done: cover property (core_done_i);
    c_dout: cover property (re_i && addr_i == OFF_DOUT);
endmodule

bind dtab_cipher dtab_cipher_checker i_chk (.clk_i(clk_i), .rst_i(rst_i),
    .addr_i(addr_i), .wdata_i(wdata_i), .we_i(we_i), .re_i(re_i),
    .rdata_o(rdata_o), .core_req_valid_o(core_req_valid_o),
    .core_req_o(core_req_o), .core_done_i(core_done_i),
    .core_data_i(core_data_i));

// ### dtab_cipher_tb.sv
// dtab_cipher_tb: self-checking bench of the cipher datapath.
// assumes: behavioural core model answers the core port.
`timescale 1ns/1ps
module dtab_cipher_tb;
    import dtab_pkg::*;
    import dtab_mdl_pkg::*;
    logic         clk_i, rst_i, we_i, re_i, vld, done;
    logic [7:0]   addr_i;
    logic [31:0]  wdata_i, rdata_o;
    logic [127:0] cdat;
    logic [63:0]  k0, k1, k2, k3;
    dtab_core_req_s req;
    int err_count = 0, n_checks = 0, cyc = 0;
    dtab_cipher i_dut (.clk_i(clk_i), .rst_i(rst_i), .addr_i(addr_i),
        .wdata_i(wdata_i), .we_i(we_i), .re_i(re_i), .rdata_o(rdata_o),
        .core_req_valid_o(vld), .core_req_o(req), .core_done_i(done),
        .core_data_i(cdat));
    dtab_core_model i_core (.clk_i(clk_i), .rst_i(rst_i),
        .req_valid_i(vld), .req_i(req), .done_o(done), .data_o(cdat));
    initial begin
        clk_i = 1'b0;
        forever #5 clk_i = ~clk_i;
    end
    // hang guard
    always @(posedge clk_i) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            err_count++;
            finish_test();
        end
    end
    task automatic chk(string nm, logic [31:0] seen, logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            err_count++;
            $display("wrong value %s: expected %h, seen %h", nm, exp, seen);
        end
    endtask
    task automatic wr(logic [7:0] a, logic [31:0] d);
        addr_i <= a;
        wdata_i <= d;
        we_i <= 1'b1;
        @(posedge clk_i);
        we_i <= 1'b0;
        @(posedge clk_i);
    endtask
    task automatic rd(logic [7:0] a, output logic [31:0] d);
        addr_i <= a;
        re_i <= 1'b1;
        @(posedge clk_i);
        re_i <= 1'b0;
        #1 d = rdata_o;
        @(posedge clk_i);
    endtask
    function automatic logic [11:0] mk(logic [3:0] alg, logic dec,
                                       logic [1:0] swp);
        return {2'h0, swp, KSZ_128, alg, dec, 1'b0};
    endfunction
    // byte reversal inside each word
    function automatic logic [127:0] sw(logic [127:0] x);
        logic [127:0] y;
        for (int i = 0; i < 16; i++) y[8*i +: 8] = x[8*(i ^ 3) +: 8];
        return y;
    endfunction
    // flush, load keys and vector, enable, feed words, drain and compare
    task automatic run(logic [11:0] ctl, logic [127:0] iv, int n,
                       logic [255:0] din, logic [255:0] dexp);
        logic [31:0]  v;
        logic [255:0] kw;
        int j;
        j = 0;
        kw = {k0, k1, k2, k3};
        wr(OFF_CTL, 32'h0000_1000);
        for (int i = 0; i < 8; i++) wr(OFF_KEY + 8'(4*i), kw[255-32*i -: 32]);
        for (int i = 0; i < 4; i++) wr(OFF_IV + 8'(4*i), iv[127-32*i -: 32]);
        wr(OFF_CTL, {20'h0, ctl | 12'h001});
        for (int i = 0; i < n; i++) wr(OFF_DIN, din[255-32*i -: 32]);
        for (int t = 0; t < 400 && j < n; t++) begin
            rd(OFF_STAT, v);
            if (v[3]) begin
                rd(OFF_DOUT, v);
                chk("output word", v, dexp[255-32*j -: 32]);
                j++;
            end
        end
        chk("word count", 32'(j), 32'(n));
        wr(OFF_CTL, 32'h0000_0000);
    endtask
    task automatic t_tdes();
        logic [63:0] p, c;
        logic [11:0] te;
        p = 64'h1111_2222_3333_4444;
        te = mk(ALG_TDES_ECB, 1'b0, SWP_NONE);
        c = de(dd(de(p, k1), k2), k3);
        run(te, 0, 2, {p, 192'h0}, {c, 192'h0});
        run(te | 12'h002, 0, 2, {c, 192'h0}, {p, 192'h0});
        run(mk(ALG_TDES_CBC, 1'b0, SWP_NONE), {k0, 64'h0}, 2, {p, 192'h0},
            {de(dd(de(p ^ k0, k1), k2), k3), 192'h0});
        c = de(dd(de(p, k1), k2), k1);
        k3 = k1;
        run(te, 0, 2, {p, 192'h0}, {c, 192'h0});
        k2 = k1;
        c = de(p, k1);
        run(te, 0, 2, {p, 192'h0}, {c, 192'h0});
        k2 = ~k1;
        run(mk(ALG_DES_ECB, 1'b0, SWP_NONE), 0, 2, {p, 192'h0},
            {c, 192'h0});
    endtask
    task automatic t_des_cbc();
        logic [63:0] p1, p2, iv, c1, c2;
        p1 = 64'h0f0f_1234_5678_9abc;
        p2 = 64'hfeed_0000_beef_0001;
        iv = 64'h5555_aaaa_0123_3210;
        c1 = de(p1 ^ iv, k1);
        c2 = de(p2 ^ c1, k1);
        run(mk(ALG_DES_CBC, 1'b0, SWP_NONE), {iv, 64'h0}, 4, {p1, p2, 128'h0},
            {c1, c2, 128'h0});
        run(mk(ALG_DES_CBC, 1'b1, SWP_NONE), {iv, 64'h0}, 4, {c1, c2, 128'h0},
            {p1, p2, 128'h0});
    endtask
    task automatic t_aes();
        logic [127:0] ka, p1, p2, iv;
        ka = {k3, k2};
        p1 = 128'h0011_2233_4455_6677_8899_aabb_ccdd_eeff;
        p2 = 128'hdead_beef_0000_ffff_1357_9bdf_2468_ace0;
        run(mk(ALG_AES_ECB, 1'b0, SWP_BYTE), 0, 4, {p1, 128'h0},
            {sw(ae(sw(p1), ka)), 128'h0});
        iv = 128'h0102_0304_0506_0708_090a_0b0c_0d0e_0f10;
        run(mk(ALG_AES_CBC, 1'b1, SWP_NONE), iv, 8, {p1, p2},
            {ad(p1, ka) ^ iv, ad(p2, ka) ^ p1});
        run(mk(ALG_AES_CBC, 1'b0, SWP_NONE), iv, 8, {p1, p2},
            {ae(p1 ^ iv, ka), ae(p2 ^ ae(p1 ^ iv, ka), ka)});
        iv = {96'h7777_0000_4444_3333_2222_1111, CTR_ONE};
        run(mk(ALG_AES_CTR, 1'b0, SWP_NONE), iv, 8, {p1, p2},
            {p1 ^ ae(iv, ka), p2 ^ ae(iv + 128'h1, ka)});
    endtask
    // gcm: hash key phase clears enable, then one payload block
    task automatic t_gcm();
        logic [31:0]  v;
        logic [127:0] iv;
        iv = {96'h0abc_1111_2222_3333_4444_5555, CTR_ONE};
        wr(OFF_CTL, {20'h0, mk(ALG_AES_GCM, 1'b0, SWP_NONE) | 12'h001});
        repeat (12) @(posedge clk_i);
        rd(OFF_CTL, v);
        chk("prep enable", v & 32'h1, 32'h0);
        run(mk(ALG_AES_GCM, 1'b0, SWP_NONE) | {PH_PAY, 10'h0}, iv, 4,
            {~iv, 128'h0},
            {~iv ^ ae(iv + 128'h1, {k3, k2}), 128'h0});
    endtask
    task automatic finish_test();
        $display("checks %0d, mismatches %0d", n_checks, err_count);
        if (err_count == 0 && n_checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    initial begin
        rst_i = 1'b1;
        we_i = 1'b0;
        re_i = 1'b0;
        addr_i = 8'h00;
        wdata_i = 32'h0000_0000;
        k0 = 64'h0bad_f00d_0bad_f00d;
        k1 = 64'h0123_4567_89ab_cdef;
        k2 = 64'h1357_2468_ace0_bdf1;
        k3 = 64'hf0e1_d2c3_b4a5_9687;
        repeat (12) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        t_aes();
        t_tdes();
        t_des_cbc();
        t_gcm();
        finish_test();
    end
endmodule
